// ===== verilog/ifx_freq_switch.sv
/*
 * ifx_freq_switch: internal oscillator frequency select and glitch-free
 * clock switch. Holds the frequency select field and the status bits.
 * Assumes the oscillators arrive as free levels on pins, start once
 * enabled, and that software writes the select field through a strobe.
 */
// Functional notes
// - postscaler taps and low-frequency oscillator feed one system clock mux.
// - the 4-bit frequency select field picks the mux input.
// - sixteen megahertz down to 31.25 kHz by postscaler, plus 31 kHz direct.
// - any reset loads the select field with 0111, 500 kHz.
// - several codes give one frequency, always from the same source.
// - a powered-down new oscillator is started and its start-up awaited.
// - after start-up, wait for a falling edge of the current clock.
// - hold output low until a rising edge of the new clock.
// - when the new clock runs, update oscillator status; switch done.
// - same source switches skip the start-up delay.
`timescale 1ns/1ps
module ifx_freq_switch import ifx_pkg::*; (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // oscillator pins
   input  wire logic             high_freq_internal_osc,
   input  wire logic             low_freq_internal_osc,
   output logic                  hf_osc_enable,
   output logic                  lf_osc_enable,
   // software side of the control register
   input  wire logic             osc_control_wr,
   input  wire logic [SEL_W-1:0] osc_control_wdata,
   output logic      [SEL_W-1:0] freq_select_field,
   // status and system clock
   output ifx_stat_t             osc_status_reg,
   output logic                  switch_busy,
   output logic                  sys_clk
);

   // synchronised oscillator levels
   logic [1:0]       osc_sync;
   logic [TAP_N-1:0] taps;
   wire              hf_lvl = osc_sync[0];
   wire              lf_lvl = osc_sync[1];

   ifx_sync2 u_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in ({low_freq_internal_osc, high_freq_internal_osc}),
      .sync_out (osc_sync)
   );

   ifx_postscaler u_post (
      .clk    (clk),
      .reset  (reset),
      .hf_lvl (hf_lvl),
      .taps   (taps)
   );

   // registers
   ifx_state_t       state_reg;
   ifx_state_t       state_next;
   logic [SEL_W-1:0] fsel_reg;
   logic [SEL_W-1:0] active_reg;
   logic [SEL_W-1:0] pend_reg;
   logic [TMR_W-1:0] tmr_reg;
   logic [TMR_W-1:0] tmr_next;
   logic [TAP_N-1:0] taps_prev_reg;
   logic             lf_prev_reg;
   logic             hf_en_reg;
   logic             lf_en_reg;
   ifx_stat_t        stat_reg;
   logic             sys_clk_reg;
   logic             sys_clk_next;
   logic             busy_reg;

   // select field picks the mux inputs
   // duplicate codes through the decode table
   // codes map to postscaler taps or the 31 kHz source
   wire ifx_src_t old_src = ifx_decode(active_reg);
   wire ifx_src_t new_src = ifx_decode(pend_reg);
   wire ifx_src_t req_src = ifx_decode(fsel_reg);

   // source levels now and one cycle earlier
   wire old_lvl      = ifx_level(old_src, taps, lf_lvl);
   wire new_lvl      = ifx_level(new_src, taps, lf_lvl);
   wire old_lvl_prev = ifx_level(old_src, taps_prev_reg, lf_prev_reg);
   wire new_lvl_prev = ifx_level(new_src, taps_prev_reg, lf_prev_reg);
   wire old_fall     = old_lvl_prev & ~old_lvl;
   wire new_rise     = ~new_lvl_prev & new_lvl;

   // source running flags
   wire old_run = old_src.lf ? stat_reg.lf_run : stat_reg.hf_run;
   wire req_run = req_src.lf ? stat_reg.lf_run : stat_reg.hf_run;
   wire new_run = new_src.lf ? stat_reg.lf_run : stat_reg.hf_run;

   // a change is pending once the field differs from the active code
   wire change_req = (state_reg == ST_RUN) && (fsel_reg != active_reg);
   wire tmr_done   = (tmr_reg == '0);
   wire [TMR_W-1:0] req_tmr = req_src.lf ? TMR_W'(LF_STARTUP_CYC)
                                         : TMR_W'(HF_STARTUP_CYC);

   // state sequencing
   always_comb begin
      state_next = state_reg;
      tmr_next   = tmr_reg;
      case (state_reg)
         ST_RUN: begin
            if (change_req) begin
               // running source goes straight to the edge wait
               if (req_run) begin
                  state_next = ST_WAIT_FAL;
               end else begin
                  state_next = ST_STARTUP;
                  tmr_next   = req_tmr;
               end
            end
         end
         ST_STARTUP: begin
            if (tmr_done) begin
               state_next = old_run ? ST_WAIT_FAL : ST_HOLD_LOW;
            end else begin
               tmr_next = tmr_reg - 1'b1;
            end
         end
         ST_WAIT_FAL: begin
            if (old_fall) begin
               state_next = ST_HOLD_LOW;
            end
         end
         ST_HOLD_LOW: begin
            if (new_rise) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   // output level
   always_comb begin
      case (state_reg)
         // held low, then the new clock
         ST_HOLD_LOW: sys_clk_next = new_rise ? new_lvl : 1'b0;
         // old clock until the low-hold step
         ST_WAIT_FAL: sys_clk_next = old_lvl;
         default:     sys_clk_next = old_run ? old_lvl : 1'b0;
      endcase
   end

   // switch start and end events
   wire entering_switch = change_req;
   wire finishing       = (state_reg == ST_HOLD_LOW) && new_rise;
   wire startup_done    = (state_reg == ST_STARTUP) && tmr_done;

   // a stopped requested oscillator is powered with the change
   wire start_hf        = entering_switch && !req_run && !req_src.lf;
   wire start_lf        = entering_switch && !req_run && req_src.lf;

   // sequencer state and start-up timer
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_STARTUP;
         tmr_reg   <= TMR_W'(HF_STARTUP_CYC);
      end else begin
         state_reg <= state_next;
         tmr_reg   <= tmr_next;
      end
   end

   // busy from a flop, tracking the next state so it matches the state register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy_reg <= 1'b1;
      end else begin
         busy_reg <= (state_next != ST_RUN);
      end
   end

   // previous source levels for edge detection
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         taps_prev_reg <= '0;
         lf_prev_reg   <= 1'b0;
      end else begin
         taps_prev_reg <= taps;
         lf_prev_reg   <= lf_lvl;
      end
   end

   // switched clock level
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sys_clk_reg <= 1'b0;
      end else begin
         sys_clk_reg <= sys_clk_next;
      end
   end

   // reset value 0111, software write afterwards
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fsel_reg <= FSEL_RESET;
      end else if (osc_control_wr) begin
         fsel_reg <= osc_control_wdata;
      end
   end

   // code being switched to, frozen for the whole switch
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pend_reg <= FSEL_RESET;
      end else if (entering_switch) begin
         pend_reg <= fsel_reg;
      end
   end

   // code now driving the output
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         active_reg <= FSEL_RESET;
      end else if (finishing) begin
         active_reg <= pend_reg;
      end
   end

   // high-frequency enable, stopped when unused after a switch
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hf_en_reg <= 1'b1;
      end else if (finishing) begin
         hf_en_reg <= ~new_src.lf;
      end else if (start_hf) begin
         hf_en_reg <= 1'b1;
      end
   end

   // low-frequency enable, stopped when unused after a switch
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lf_en_reg <= 1'b0;
      end else if (finishing) begin
         lf_en_reg <= new_src.lf;
      end else if (start_lf) begin
         lf_en_reg <= 1'b1;
      end
   end

   // status shows the oscillators that run
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stat_reg <= '0;
      end else if (finishing) begin
         stat_reg.hf_run <= ~new_src.lf;
         stat_reg.lf_run <= new_src.lf;
      end else if (startup_done && new_src.lf) begin
         stat_reg.lf_run <= 1'b1;
      end else if (startup_done) begin
         stat_reg.hf_run <= 1'b1;
      end
   end

   assign hf_osc_enable     = hf_en_reg;
   assign lf_osc_enable     = lf_en_reg;
   assign freq_select_field = fsel_reg;
   assign osc_status_reg    = stat_reg;
   assign switch_busy       = busy_reg;
   assign sys_clk           = sys_clk_reg;

endmodule

// ===== verilog/ifx_pkg.sv
/*
 * ifx_pkg: constants, types and helpers shared by the internal oscillator
 * frequency select switch and its two helper modules.
 * Assumes a single 100 MHz system clock that samples both oscillators.
 */
package ifx_pkg;

   // clock rate of the sampling logic
   localparam int unsigned CLK_FREQ_MHZ = 100;

   // oscillator start-up times, in nanoseconds
   localparam int unsigned HF_STARTUP_NS = 5000;
   localparam int unsigned LF_STARTUP_NS = 2000;

   // least times round up to whole cycles
   localparam int unsigned HF_STARTUP_CYC = (HF_STARTUP_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int unsigned LF_STARTUP_CYC = (LF_STARTUP_NS * CLK_FREQ_MHZ + 999) / 1000;

   // start-up timer, postscaler and select field widths
   localparam int unsigned TMR_W  = 12;
   localparam int unsigned DIV_W  = 4;
   localparam int unsigned TAP_N  = 10;
   localparam int unsigned SEL_W  = 4;

   // frequency select field after any reset: 500 kHz
   localparam logic [3:0] FSEL_RESET = 4'h7;

   // postscaler divide exponents: 16 MHz / 2^n
   localparam logic [3:0] DIV_16M   = 4'h0;
   localparam logic [3:0] DIV_8M    = 4'h1;
   localparam logic [3:0] DIV_4M    = 4'h2;
   localparam logic [3:0] DIV_2M    = 4'h3;
   localparam logic [3:0] DIV_1M    = 4'h4;
   localparam logic [3:0] DIV_500K  = 4'h5;
   localparam logic [3:0] DIV_250K  = 4'h6;
   localparam logic [3:0] DIV_125K  = 4'h7;
   localparam logic [3:0] DIV_62K5  = 4'h8;
   localparam logic [3:0] DIV_31K25 = 4'h9;

   // oscillator status field positions
   localparam int unsigned STAT_HF_BIT = 0;
   localparam int unsigned STAT_LF_BIT = 1;

   // decoded source: low-frequency oscillator or high-frequency postscaler tap
   typedef struct packed {
      logic       lf;
      logic [3:0] div;
   } ifx_src_t;

   // oscillator status register content
   typedef struct packed {
      logic lf_run;
      logic hf_run;
   } ifx_stat_t;

   typedef enum logic [3:0] {
      ST_RUN      = 4'b0001,
      ST_STARTUP  = 4'b0010,
      ST_WAIT_FAL = 4'b0100,
      ST_HOLD_LOW = 4'b1000
   } ifx_state_t;

   // frequency select code to source; duplicate codes share a frequency
   function automatic ifx_src_t ifx_decode(input logic [3:0] code);
      ifx_src_t s;
      s.lf  = 1'b0;
      s.div = DIV_31K25;
      case (code)
         4'h0, 4'h1: s.lf = 1'b1;
         4'h2, 4'h3: s.div = DIV_31K25;
         4'h4:       s.div = DIV_62K5;
         4'h5, 4'h8: s.div = DIV_125K;
         4'h6, 4'h9: s.div = DIV_250K;
         4'h7, 4'ha: s.div = DIV_500K;
         4'hb:       s.div = DIV_1M;
         4'hc:       s.div = DIV_2M;
         4'hd:       s.div = DIV_4M;
         4'he:       s.div = DIV_8M;
         default:    s.div = DIV_16M;
      endcase
      return s;
   endfunction

   // level of the chosen source out of the tap vector or the low-frequency level
   function automatic logic ifx_level(input ifx_src_t s, input logic [TAP_N-1:0] taps,
                                      input logic lf_lvl);
      return s.lf ? lf_lvl : taps[s.div];
   endfunction

endpackage

// ===== verilog/ifx_sync2.sv
/*
 * ifx_sync2: two-flop synchroniser for the raw oscillator levels.
 * Assumes inputs are asynchronous to clk.
 */
`timescale 1ns/1ps
module ifx_sync2 import ifx_pkg::*; (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // asynchronous levels in, synchronised levels out
   input  wire logic [1:0] async_in,
   output logic      [1:0] sync_out
);
   logic [1:0] meta_reg;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_reg <= 2'h0;
         sync_out <= 2'h0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// ===== verilog/ifx_postscaler.sv
/*
 * ifx_postscaler: binary postscaler on the high-frequency oscillator.
 * Assumes hf_lvl is already synchronised to clk; tap n is hf / 2^n.
 */
`timescale 1ns/1ps
module ifx_postscaler import ifx_pkg::*; (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // synchronised oscillator level
   input  wire logic             hf_lvl,
   // divided levels, tap 0 is the oscillator itself
   output logic      [TAP_N-1:0] taps
);
   logic             hf_prev_reg;
   logic [TAP_N-2:0] cnt_reg;
   wire              hf_fall = hf_prev_reg & ~hf_lvl;

   // counting falling edges makes each divided tap change one cycle after the oscillator falls
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hf_prev_reg <= 1'b0;
         cnt_reg     <= '0;
      end else begin
         hf_prev_reg <= hf_lvl;
         if (hf_fall) begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   assign taps = {cnt_reg, hf_lvl};
endmodule

// ===== verification/ifx_freq_switch_checker.sv
/* ifx_freq_switch_checker: port assertions for the frequency switch.
   Assumes one clk domain, async active-high reset, bound to the top. */
`timescale 1ns/1ps
module ifx_freq_switch_checker import ifx_pkg::*; (
   // clock and reset
   input wire logic       clk,
   input wire logic       reset,
   // oscillator pins
   input wire logic       high_freq_internal_osc,
   input wire logic       low_freq_internal_osc,
   input wire logic       hf_osc_enable,
   input wire logic       lf_osc_enable,
   // control and status
   input wire logic       osc_control_wr,
   input wire logic [3:0] osc_control_wdata,
   input wire logic [3:0] freq_select_field,
   input wire ifx_stat_t  osc_status_reg,
   input wire logic       switch_busy,
   input wire logic       sys_clk
);
   logic [11:0] hf_age_reg;
   logic [11:0] lf_age_reg;
   logic [3:0]  tgt_reg;

   // code the current switch heads for, taken while idle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tgt_reg <= FSEL_RESET;
      end else if (!switch_busy) begin
         tgt_reg <= freq_select_field;
      end
   end

   // cycles each oscillator has been powered, saturating
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hf_age_reg <= 12'h000;
         lf_age_reg <= 12'h000;
      end else begin
         hf_age_reg <= hf_osc_enable ? hf_age_reg + 12'(hf_age_reg != 12'hfff) : 12'h000;
         lf_age_reg <= lf_osc_enable ? lf_age_reg + 12'(lf_age_reg != 12'hfff) : 12'h000;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   a_fsel_reset_val: assert property ($fell(reset) |-> freq_select_field == FSEL_RESET)
      else $error("select field wrong after reset");
   a_write_loads_field: assert property (osc_control_wr |=>
      freq_select_field == $past(osc_control_wdata)) else $error("write not taken");
   a_field_holds: assert property (!osc_control_wr |=> $stable(freq_select_field))
      else $error("field changed without write");
   a_busy_on_change: assert property ($changed(freq_select_field) && !switch_busy
      |=> switch_busy) else $error("no switch after field change");
   a_done_clk_high: assert property ($fell(switch_busy) |-> sys_clk)
      else $error("new clock not high at switch end");
   a_done_status: assert property ($fell(switch_busy) |->
      osc_status_reg == {lf_osc_enable, hf_osc_enable}) else $error("status stale");
   a_done_source: assert property ($fell(switch_busy) |->
      hf_osc_enable == (tgt_reg > 4'h1) && lf_osc_enable == (tgt_reg < 4'h2))
      else $error("wrong oscillator selected");
   a_high_no_cut: assert property ($rose(sys_clk) |=> sys_clk [*3])
      else $error("system clock high phase cut short");
   a_hf_startup_wait: assert property ($rose(osc_status_reg.hf_run) |->
      hf_age_reg >= HF_STARTUP_CYC - 1) else $error("hf start-up cut short");
   a_lf_startup_wait: assert property ($rose(osc_status_reg.lf_run) |->
      lf_age_reg >= LF_STARTUP_CYC - 1) else $error("lf start-up cut short");

   c_to_lf: cover property ($fell(switch_busy) && lf_osc_enable);
   c_to_hf: cover property ($fell(switch_busy) && hf_osc_enable);
   c_write: cover property (osc_control_wr && !switch_busy);
endmodule

bind ifx_freq_switch ifx_freq_switch_checker chk_u (.clk, .reset, .high_freq_internal_osc,
   .low_freq_internal_osc, .hf_osc_enable, .lf_osc_enable, .osc_control_wr,
   .osc_control_wdata, .freq_select_field, .osc_status_reg, .switch_busy, .sys_clk);

// ===== verification/tb.sv
/* tb: self-checking bench for the frequency switch.
   Assumes hf tap period 8 cycles, lf period 100 cycles, made here. */
`timescale 1ns/1ps
module tb;
   import ifx_pkg::*;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic       hf_osc = 1'b0;
   logic       lf_osc = 1'b0;
   logic       wr = 1'b0;
   logic [3:0] wdata = 4'h0;
   logic [3:0] field;
   ifx_stat_t  status;
   logic       hf_en, lf_en, busy, sys_clk;
   logic [3:0] exp_q[$];
   logic [3:0] cur = 4'h7;
   logic [3:0] c;
   logic [1:0] osc_cnt = 2'h0;
   int         lf_cnt = 0;
   int         mismatches = 0;
   int         check_count = 0;
   int         pushes = 0;
   int         done_cnt = 0;
   int         seed = 92878;
   int         per_tab[16] = '{100, 100, 4096, 4096, 2048, 1024, 512, 256,
                               1024, 512, 256, 128, 64, 32, 16, 8};

   ifx_freq_switch dut_u (.clk(clk), .reset(reset), .high_freq_internal_osc(hf_osc),
      .low_freq_internal_osc(lf_osc), .hf_osc_enable(hf_en), .lf_osc_enable(lf_en),
      .osc_control_wr(wr), .osc_control_wdata(wdata), .freq_select_field(field),
      .osc_status_reg(status), .switch_busy(busy), .sys_clk(sys_clk));

   always #5 clk = ~clk;

   // oscillators stand still while powered down
   always @(posedge clk) begin
      osc_cnt <= osc_cnt + 2'h1;
      lf_cnt <= (lf_cnt == 49) ? 0 : lf_cnt + 1;
      if (hf_en === 1'b1 && osc_cnt == 2'h3) hf_osc <= ~hf_osc;
      if (lf_en === 1'b1 && lf_cnt == 49) lf_osc <= ~lf_osc;
   end

   task automatic check(input bit ok, input string m);
      check_count++;
      if (!ok) begin
         mismatches++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // waits for the monitor to finish all notes, counting busy cycles
   task automatic settle(output int b);
      int n;
      n = 0;
      b = 0;
      while (done_cnt != pushes && n < 20000) begin
         @(posedge clk);
         n++;
         b += int'(busy === 1'b1);
      end
      check(n < 20000, "switch never completed");
   endtask

   task automatic sel(input logic [3:0] v);
      int b;
      @(posedge clk);
      wr <= 1'b1;
      wdata <= v;
      exp_q.push_back(v);
      pushes++;
      @(posedge clk);
      wr <= 1'b0;
      settle(b);
      if (v > 1 && cur > 1 && per_tab[v] + per_tab[cur] < 400)
         check(b < HF_STARTUP_CYC, "same-source switch waited for start-up");
      cur = v;
      $display("test select %h done", v);
   endtask

   // monitor: each end of a switch takes the oldest note
   always begin
      logic [3:0] e;
      time        t0;
      @(negedge busy);
      t0 = $time;
      #1;
      e = exp_q.pop_front();
      check(field === e && sys_clk === 1'b1, "field or clock at switch end");
      check(status === ((e < 2) ? 2'b10 : 2'b01), "status wrong");
      check(hf_en === (e > 1) && lf_en === (e < 2), "oscillator enables wrong");
      @(posedge sys_clk);
      check(($time - t0) / 10 == per_tab[e], "system clock period wrong");
      done_cnt++;
   end

   initial begin
      int b;
      exp_q.push_back(4'h7);
      pushes = 1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      settle(b);
      $display("test reset done");
      for (int i = 0; i < 16; i++)
         sel(4'(i));
      @(posedge clk);
      reset <= 1'b1;
      exp_q.push_back(4'h7);
      pushes++;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      settle(b);
      cur = 4'h7;
      $display("test mid-run reset done");
      repeat (4) begin
         c = 4'($random(seed));
         if (c != cur) sel(c);
      end
      tally_and_finish();
   end

   initial begin
      #1000000;
      mismatches++;
      tally_and_finish();
   end
endmodule
